// ===== design/scram_vote_bypass_logic.sv
// Local design decisions: the plain strobed port and the register addresses.
`timescale 1ns/1ps
module scram_vote_bypass_logic
  import scram_pkg::*;
#(
  parameter int ADDR_W = 8
) (
  // clock and reset
  input  wire logic              mclk_i,
  input  wire logic              rstn_i,
  // register port
  input  wire logic [ADDR_W-1:0] addr_i,
  input  wire logic [31:0]       wdata_i,
  input  wire logic              wr_i,
  input  wire logic              rd_i,
  output logic      [31:0]       rdata_o,
  // sensor channel trips, one bit per channel
  input  wire logic [3:0]        low_level_i,
  input  wire logic [3:0]        steam_rad_i,
  input  wire logic [3:0]        drywell_press_i,
  input  wire logic [3:0]        vessel_press_i,
  input  wire logic [3:0]        pool_temp_i,
  input  wire logic [3:0]        accum_press_low_i,
  input  wire logic [3:0]        siv_closed_i,
  input  wire logic [3:0]        stop_valve_closed_i,
  input  wire logic [3:0]        valve_hydraulic_oil_loss_i,
  input  wire logic [3:0]        first_stage_low_i,
  // neutron monitor trips
  input  wire logic [3:0]        power_range_flux_monitor_trip_i,
  input  wire logic [3:0]        startup_range_flux_i,
  input  wire logic [3:0]        startup_range_period_i,
  input  wire logic [3:0]        startup_range_inop_i,
  // operator switches
  input  wire logic [3:0]        chan_byp_sw_i,
  input  wire logic [3:0]        div_byp_sw_i,
  input  wire logic              accum_byp_sw_i,
  input  wire logic [7:0]        mode_sw_i,
  input  wire logic              manual_pb_a_i,
  input  wire logic              manual_pb_b_i,
  // scram and annunciation
  output logic                   scram_o,
  output logic      [3:0]        div_trip_o,
  output logic      [3:0]        chan_byp_flag_o,
  output logic      [3:0]        div_byp_flag_o,
  output logic      [3:0]        accum_byp_flag_o,
  output logic      [3:0]        siv_chan_byp_flag_o
);

  // ==========================================
  // elaboration checks, the map needs four address bits
  if (ADDR_W < 4) begin : g_addr_w_check
    $error("ADDR_W too small for register map");
  end

  // ==========================================
  // input synchronisers
  localparam int SYNC_W = 75;

  logic [SYNC_W-1:0] raw;
  logic [SYNC_W-1:0] sync1;
  logic [SYNC_W-1:0] sync2;
  logic [SYNC_W-1:0] sync3;
  logic [SYNC_W-1:0] filt;

  // all pin inputs packed in one vector
  assign raw = {low_level_i, steam_rad_i, drywell_press_i,
                vessel_press_i, pool_temp_i, accum_press_low_i,
                siv_closed_i, stop_valve_closed_i,
                valve_hydraulic_oil_loss_i, first_stage_low_i,
                power_range_flux_monitor_trip_i, startup_range_flux_i,
                startup_range_period_i, startup_range_inop_i,
                chan_byp_sw_i, div_byp_sw_i, accum_byp_sw_i,
                mode_sw_i, manual_pb_a_i, manual_pb_b_i};

  // three stage chain
  always_ff @(posedge mclk_i) begin
    if (!rstn_i) begin
      sync1 <= '0;
      sync2 <= '0;
      sync3 <= '0;
    end else begin
      sync1 <= raw;
      sync2 <= sync1;
      sync3 <= sync2;
    end
  end

  // accept a bit once stages two and three agree
  // a pulse shorter than two edges never reaches the vote logic
  genvar gb;
  generate
    for (gb = 0; gb < SYNC_W; gb++) begin : g_filt
      always_ff @(posedge mclk_i) begin
        if (!rstn_i) begin
          filt[gb] <= 1'b0;
        end else if (sync2[gb] == sync3[gb]) begin
          filt[gb] <= sync3[gb];
        end
      end
    end
  endgenerate

  // ==========================================
  // unpack filtered inputs
  logic [3:0] f_low;
  logic [3:0] f_rad;
  logic [3:0] f_dry;
  logic [3:0] f_vp;
  logic [3:0] f_pool;
  logic [3:0] f_acc;
  logic [3:0] f_siv;
  logic [3:0] f_stop;
  logic [3:0] f_oil;
  logic [3:0] f_fsp;
  logic [3:0] f_pr;
  logic [3:0] f_srf;
  logic [3:0] f_srp;
  logic [3:0] f_sri;
  logic [3:0] f_chsw;
  logic [3:0] f_dvsw;
  logic       f_accsw;
  logic [7:0] f_mode;
  logic       f_pba;
  logic       f_pbb;

  assign {f_low, f_rad, f_dry, f_vp, f_pool, f_acc, f_siv, f_stop,
          f_oil, f_fsp, f_pr, f_srf, f_srp, f_sri, f_chsw, f_dvsw,
          f_accsw, f_mode, f_pba, f_pbb} = filt;

  // startup range trip from any of its three causes
  logic [3:0] sr_any;
  assign sr_any = f_srf | f_srp | f_sri;

  // ==========================================
  // sensor channel bypass selection
  logic [3:0] chan_act;

  // hold the first request, ignore later ones
  // a switch set while another bypass stands takes over one edge after that bypass drops, if still set
  always_ff @(posedge mclk_i) begin
    if (!rstn_i) begin
      chan_act <= 4'h0;
    end else if (chan_act == 4'h0) begin
      chan_act <= lowest_bit(f_chsw);
    end else if ((chan_act & f_chsw) == 4'h0) begin
      chan_act <= 4'h0;
    end
  end

  assign chan_byp_flag_o = chan_act;

  // ==========================================
  // division bypass selection
  logic [3:0] div_act;

  // same single-bypass discipline for divisions
  // a division bypass never masks neutron or manual trips
  always_ff @(posedge mclk_i) begin
    if (!rstn_i) begin
      div_act <= 4'h0;
    end else if (div_act == 4'h0) begin
      div_act <= lowest_bit(f_dvsw);
    end else if ((div_act & f_dvsw) == 4'h0) begin
      div_act <= 4'h0;
    end
  end

  assign div_byp_flag_o = div_act;

  // ==========================================
  // accumulator pressure operating bypass
  logic [3:0] acc_byp;

  genvar gd;
  generate
    for (gd = 0; gd < N_CH; gd++) begin : g_acc
      logic [1:0] dmode;
      assign dmode = f_mode[2*gd +: 2];
      // follows switch, dropped outside shutdown or refuel
      // moving to startup drops it even with the switch still set
      always_ff @(posedge mclk_i) begin
        if (!rstn_i) begin
          acc_byp[gd] <= 1'b0;
        end else if (!f_accsw || dmode == MODE_STARTUP) begin
          acc_byp[gd] <= 1'b0;
        end else if (dmode == MODE_SHUTDOWN || dmode == MODE_REFUEL) begin
          acc_byp[gd] <= 1'b1;
        end else begin
          acc_byp[gd] <= 1'b0;
        end
      end
    end
  endgenerate

  assign accum_byp_flag_o = acc_byp;

  // ==========================================
  // register port decode
  logic wr_ctrl;
  logic wr_siv;
  logic scram_clr;

  assign wr_ctrl   = wr_i && (addr_i == ADDR_W'(REG_CTRL));
  assign wr_siv    = wr_i && (addr_i == ADDR_W'(REG_SIV));
  assign scram_clr = wr_ctrl && wdata_i[CTRL_RESET];

  // ==========================================
  // single channel isolation valve bypass
  logic [3:0] siv_byp;
  logic       siv_cancel;
  logic       siv_ok;

  // any other channel bypass ends it
  assign siv_cancel = (chan_act != 4'h0) && (chan_act != siv_byp);
  assign siv_ok     = (wdata_i[3:0] == lowest_bit(wdata_i[3:0])) &&
                      ((chan_act == 4'h0) || (chan_act == wdata_i[3:0]));

  // cancel wins over a write
  // while a channel bypass stands, a write naming another channel stores zero, as does any write naming two or more channels
  always_ff @(posedge mclk_i) begin
    if (!rstn_i) begin
      siv_byp <= SIV_RST;
    end else if (siv_cancel) begin
      siv_byp <= 4'h0;
    end else if (wr_siv) begin
      siv_byp <= siv_ok ? wdata_i[3:0] : 4'h0;
    end
  end

  assign siv_chan_byp_flag_o = siv_byp;

  // ==========================================
  // division logic instances
  // every division sees all four channels but its own mode pair
  logic [3:0] div_sens;
  logic [3:0] div_nms;

  generate
    for (gd = 0; gd < N_CH; gd++) begin : g_div
      division_if dif ();

      assign dif.ch_trip[S_LOW_LEVEL] = f_low;
      assign dif.ch_trip[S_STEAM_RAD] = f_rad;
      assign dif.ch_trip[S_DRYWELL]   = f_dry;
      assign dif.ch_trip[S_VESSEL_P]  = f_vp;
      assign dif.ch_trip[S_POOL_TEMP] = f_pool;
      assign dif.ch_trip[S_ACCUM_LOW] = f_acc;
      assign dif.ch_trip[S_SIV_CLOSE] = f_siv;
      assign dif.ch_trip[S_STOP_VLV]  = f_stop;
      assign dif.ch_trip[S_FAST_CLS]  = f_oil;
      assign dif.pr_trip = f_pr;
      assign dif.sr_trip = sr_any;
      assign dif.fsp_low = f_fsp;
      assign dif.ch_byp  = chan_act;
      assign dif.siv_byp = siv_byp;
      assign dif.mode    = f_mode[2*gd +: 2];
      assign dif.acc_byp = acc_byp[gd];

      division_vote u_vote (
        .d (dif.div)
      );

      assign div_sens[gd] = dif.sens_trip;
      assign div_nms[gd]  = dif.nms_trip;
    end
  endgenerate

  // ==========================================
  // scram vote and seal-in
  logic sens_vote;
  logic nms_vote;
  logic manual;
  logic scram_set;
  logic scram;
  logic [3:0] div_trip;

  // bypassed division drops out of sensor vote only
  assign sens_vote = two_of(div_sens & ~div_act);
  assign nms_vote  = two_of(div_nms);
  assign manual    = f_pba & f_pbb;
  assign scram_set = sens_vote | nms_vote | manual;

  // set wins over a software reset
  // the latch holds after the sensors return to normal
  always_ff @(posedge mclk_i) begin
    if (!rstn_i) begin
      scram <= 1'b0;
    end else if (scram_set) begin
      scram <= 1'b1;
    end else if (scram_clr) begin
      scram <= 1'b0;
    end
  end

  // registered division trip indication
  always_ff @(posedge mclk_i) begin
    if (!rstn_i) begin
      div_trip <= 4'h0;
    end else begin
      div_trip <= div_sens | div_nms;
    end
  end

  assign scram_o    = scram;
  assign div_trip_o = div_trip;

  // ==========================================
  // register read
  logic [31:0] rd_val;

  // status fields, unused bits read zero
  // reads have no side effects on the latch or the bypasses
  always_comb begin
    rd_val = 32'h0000_0000;
    if (addr_i == ADDR_W'(REG_SIV)) begin
      rd_val[3:0] = siv_byp;
    end else if (addr_i == ADDR_W'(REG_STATUS)) begin
      rd_val[0]     = scram;
      rd_val[7:4]   = chan_act;
      rd_val[11:8]  = div_act;
      rd_val[15:12] = acc_byp;
      rd_val[16]    = manual;
    end else if (addr_i == ADDR_W'(REG_TRIPS)) begin
      rd_val[3:0]   = div_sens;
      rd_val[7:4]   = div_nms;
      rd_val[8]     = sens_vote;
      rd_val[9]     = nms_vote;
    end
  end

  // data valid only in the cycle after the strobe
  always_ff @(posedge mclk_i) begin
    if (!rstn_i) begin
      rdata_o <= RDATA_RST;
    end else if (rd_i) begin
      rdata_o <= rd_val;
    end else begin
      rdata_o <= RDATA_RST;
    end
  end

endmodule

// ===== common/scram_pkg.sv
// Notes on behaviour
// - a bypassed sensor channel turns every division's 2/4 channel vote into 2/3
// - at most one sensor channel is bypassed at any time
// - a flag shows which sensor channel is bypassed
// - a bypassed division turns the sensor trip vote into 2 of 3 divisions
// - at most one division is bypassed at any time
// - a flag shows which division is bypassed
// - channel and division bypasses never mask neutron monitor trips or manual scram
// - level, radiation, power flux, drywell, vessel pressure, pool trips never bypassed
// - accumulator pressure bypass allowed only in shutdown or refuel
// - accumulator bypass drops when its switch clears or mode is startup
// - isolation valve closure trip bypassed in shutdown, refuel or startup
// - startup range flux monitor trip bypassed in run
// - each division uses its own mode switch signal
// - stop valve and fast closure trips bypassed in shutdown, refuel, startup
// - turbine valve trips bypassed while first stage pressure is low
// - hydraulic oil pressure loss is the fast closure trip input
// - startup flux trip is flux trip, short period or inoperative
// - single channel isolation valve bypass cancels on other channel bypass
// - a satisfied vote latches scram until software resets it
// - manual scram needs both pushbuttons at once
package scram_pkg;

  // ==========================================
  // channels, sensor trip indices
  localparam int N_CH        = 4;
  localparam int S_LOW_LEVEL = 0;
  localparam int S_STEAM_RAD = 1;
  localparam int S_DRYWELL   = 2;
  localparam int S_VESSEL_P  = 3;
  localparam int S_POOL_TEMP = 4;
  localparam int S_ACCUM_LOW = 5;
  localparam int S_SIV_CLOSE = 6;
  localparam int S_STOP_VLV  = 7;
  localparam int S_FAST_CLS  = 8;
  localparam int N_SENS      = 9;

  // ==========================================
  // mode switch codes
  localparam logic [1:0] MODE_SHUTDOWN = 2'h0;
  localparam logic [1:0] MODE_REFUEL   = 2'h1;
  localparam logic [1:0] MODE_STARTUP  = 2'h2;
  localparam logic [1:0] MODE_RUN      = 2'h3;

  // ==========================================
  // register map and reset values
  localparam logic [7:0]  REG_CTRL    = 8'h00;
  localparam logic [7:0]  REG_SIV     = 8'h04;
  localparam logic [7:0]  REG_STATUS  = 8'h08;
  localparam logic [7:0]  REG_TRIPS   = 8'h0C;
  localparam int          CTRL_RESET  = 0;
  localparam logic [3:0]  SIV_RST     = 4'h0;
  localparam logic [31:0] RDATA_RST   = 32'h0000_0000;

  // true when at least two bits of four are set
  function automatic logic two_of(input logic [3:0] v);
    return (v[0] & v[1]) | (v[0] & v[2]) | (v[0] & v[3]) |
           (v[1] & v[2]) | (v[1] & v[3]) | (v[2] & v[3]);
  endfunction

  // lowest set bit only
  function automatic logic [3:0] lowest_bit(input logic [3:0] v);
    return v & (~v + 4'h1);
  endfunction

endpackage

// ===== common/division_if.sv
`timescale 1ns/1ps
interface division_if;
  import scram_pkg::*;
  logic [3:0] ch_trip [N_SENS];
  logic [3:0] pr_trip;
  logic [3:0] sr_trip;
  logic [3:0] fsp_low;
  logic [3:0] ch_byp;
  logic [3:0] siv_byp;
  logic [1:0] mode;
  logic       acc_byp;
  logic       sens_trip;
  logic       nms_trip;

  modport top (output ch_trip, pr_trip, sr_trip, fsp_low, ch_byp, siv_byp,
               output mode, acc_byp, input sens_trip, nms_trip);
  modport div (input ch_trip, pr_trip, sr_trip, fsp_low, ch_byp, siv_byp,
               input mode, acc_byp, output sens_trip, nms_trip);
endinterface

// ===== design/division_vote.sv
`timescale 1ns/1ps
module division_vote
  import scram_pkg::*;
(
  // division link
  division_if.div d
);

  logic       low_power_mode;
  logic [3:0] opbyp [N_SENS];
  logic [N_SENS-1:0] var_trip;

  // own mode signal of this division
  assign low_power_mode = (d.mode != MODE_RUN);

  // operating bypass per variable and channel
  always_comb begin
    for (int v = 0; v < N_SENS; v++) begin
      opbyp[v] = 4'h0;
    end
    opbyp[S_ACCUM_LOW] = {4{d.acc_byp}};
    opbyp[S_SIV_CLOSE] = {4{low_power_mode}} | d.siv_byp;
    opbyp[S_STOP_VLV]  = {4{low_power_mode}} | d.fsp_low;
    opbyp[S_FAST_CLS]  = {4{low_power_mode}} | d.fsp_low;
  end

  // channel coincidence, bypassed channel left out
  genvar gv;
  generate
    for (gv = 0; gv < N_SENS; gv++) begin : g_var
      assign var_trip[gv] = two_of(d.ch_trip[gv] & ~d.ch_byp & ~opbyp[gv]);
    end
  endgenerate

  assign d.sens_trip = |var_trip;

  // neutron monitor votes ignore channel bypass
  assign d.nms_trip = two_of(d.pr_trip) |
                      (two_of(d.sr_trip) & (d.mode != MODE_RUN));

endmodule

// ===== tb/scram_vote_bypass_logic_assertions.sv
`timescale 1ns/1ps
module scram_vote_bypass_logic_assertions
  import scram_pkg::*;
#(
  parameter int ADDR_W = 8
) (
  // clock, reset, bus
  input wire logic              mclk_i,
  input wire logic              rstn_i,
  input wire logic [ADDR_W-1:0] addr_i,
  input wire logic [31:0]       wdata_i,
  input wire logic              wr_i,
  // pins
  input wire logic [3:0]        low_level_i,
  input wire logic [3:0]        power_range_flux_monitor_trip_i,
  input wire logic [3:0]        chan_byp_sw_i,
  input wire logic [3:0]        div_byp_sw_i,
  input wire logic              accum_byp_sw_i,
  input wire logic [7:0]        mode_sw_i,
  input wire logic              manual_pb_a_i,
  input wire logic              manual_pb_b_i,
  // outputs
  input wire logic              scram_o,
  input wire logic [3:0]        div_trip_o,
  input wire logic [3:0]        chan_byp_flag_o,
  input wire logic [3:0]        div_byp_flag_o,
  input wire logic [3:0]        accum_byp_flag_o,
  input wire logic [3:0]        siv_chan_byp_flag_o
);
  // ==========================================
  // request history over eight edges
  logic [31:0] cb_h, db_h, ab_h;
  logic [3:0]  ab_ok;
  logic        clr;

  assign ab_ok = {4{accum_byp_sw_i}} & ~{mode_sw_i[7], mode_sw_i[5], mode_sw_i[3], mode_sw_i[1]};
  assign clr   = wr_i && addr_i == ADDR_W'(REG_CTRL) && wdata_i[0];

  // shift in each edge
  always_ff @(posedge mclk_i) begin
    cb_h <= {cb_h[27:0], chan_byp_sw_i};
    db_h <= {db_h[27:0], div_byp_sw_i};
    ab_h <= {ab_h[27:0], ab_ok};
  end

  // any request seen in the window
  function automatic logic [3:0] any8(input logic [31:0] h);
    logic [3:0] r;
    r = 4'h0;
    for (int i = 0; i < 8; i++) r |= h[4*i +: 4];
    return r;
  endfunction

  // ==========================================
  // properties
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!rstn_i);

  sequence both_held;
    (manual_pb_a_i && manual_pb_b_i) [*8];
  endsequence
  sequence level_held;
    ($countones(low_level_i) >= 2 && chan_byp_sw_i == 4'h0) [*8];
  endsequence
  sequence flux_held;
    ($countones(power_range_flux_monitor_trip_i) >= 2) [*8];
  endsequence

  a_chan_one_hot: assert property ($onehot0(chan_byp_flag_o))
    else $error("two channel bypasses");
  a_div_one_hot: assert property ($onehot0(div_byp_flag_o))
    else $error("two division bypasses");
  a_chan_flag_cause: assert property ((chan_byp_flag_o & ~any8(cb_h)) == 4'h0)
    else $error("channel flag without switch");
  a_div_flag_cause: assert property ((div_byp_flag_o & ~any8(db_h)) == 4'h0)
    else $error("division flag without switch");
  a_accum_flag_cause: assert property ((accum_byp_flag_o & ~any8(ab_h)) == 4'h0)
    else $error("accumulator bypass outside its modes");
  a_chan_flag_hold: assert property (chan_byp_flag_o != 4'h0 && $past(chan_byp_flag_o) != 4'h0
    |-> chan_byp_flag_o == $past(chan_byp_flag_o)) else $error("channel bypass moved");
  a_scram_latch_hold: assert property ($fell(scram_o) && $past(rstn_i)
    |-> $past(clr) || $past(clr, 2)) else $error("scram dropped without clear");
  a_manual_scram: assert property (both_held |=> scram_o)
    else $error("both buttons without scram");
  a_level_scram: assert property (level_held |=> scram_o && div_trip_o == 4'hF)
    else $error("low level vote without scram");
  a_flux_scram: assert property (flux_held |=> scram_o && div_trip_o == 4'hF)
    else $error("flux vote without scram");
  a_siv_cancel: assert property ((chan_byp_flag_o & ~siv_chan_byp_flag_o) != 4'h0
    |=> siv_chan_byp_flag_o == 4'h0) else $error("valve bypass kept");
endmodule

bind scram_vote_bypass_logic scram_vote_bypass_logic_assertions #(.ADDR_W(ADDR_W)) u_chk (
  .mclk_i, .rstn_i, .addr_i, .wdata_i, .wr_i, .low_level_i, .power_range_flux_monitor_trip_i,
  .chan_byp_sw_i, .div_byp_sw_i, .accum_byp_sw_i, .mode_sw_i, .manual_pb_a_i, .manual_pb_b_i,
  .scram_o, .div_trip_o, .chan_byp_flag_o, .div_byp_flag_o, .accum_byp_flag_o,
  .siv_chan_byp_flag_o);

// ===== tb/plant_model.sv
`timescale 1ns/1ps
module plant_model (
  // clock
  input  wire logic       mclk_i,
  // sensor, switch and mode pins
  output logic      [3:0] pin_o [16],
  output logic      [7:0] mode_o,
  output logic            accum_o,
  output logic            pb_a_o,
  output logic            pb_b_o
);
  // quiet plant at time zero
  initial begin
    foreach (pin_o[k]) pin_o[k] = 4'h0;
    mode_o  = 8'h00;
    accum_o = 1'b0;
    pb_a_o  = 1'b0;
    pb_b_o  = 1'b0;
  end

  // one pin group a call, slot 8 oil loss, 11 to 13 startup flux lines
  task automatic put(input int k, input logic [3:0] v);
    @(posedge mclk_i);
    pin_o[k] <= v;
  endtask

  // one mode line pair per division, plus switches
  task automatic sw(input logic [7:0] m, input logic a, input logic b, input logic c);
    @(posedge mclk_i);
    mode_o  <= m;
    accum_o <= a;
    pb_a_o  <= b;
    pb_b_o  <= c;
  endtask
endmodule

// ===== tb/scram_vote_bypass_logic_bench.sv
`timescale 1ns/1ps
module scram_vote_bypass_logic_bench;
  import scram_pkg::*;

  // ==========================================
  // signals
  logic        mclk_i, rstn_i, wr_i, rd_i, rd_d, scram_o, accum, pb_a, pb_b, s;
  logic [7:0]  addr_i, mode;
  logic [31:0] wdata_i, rdata_o, t;
  logic [3:0]  pin [16];
  logic [3:0]  div_trip_o, chan_byp_flag_o, div_byp_flag_o, accum_byp_flag_o, siv_chan_byp_flag_o;
  logic [3:0]  c;
  logic [31:0] exp_q [$];
  int          a, n_mismatch, samples_checked;

  scram_vote_bypass_logic u_scram_vote_bypass_logic (
    .mclk_i, .rstn_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o,
    .low_level_i(pin[0]), .steam_rad_i(pin[1]), .drywell_press_i(pin[2]),
    .vessel_press_i(pin[3]), .pool_temp_i(pin[4]), .accum_press_low_i(pin[5]),
    .siv_closed_i(pin[6]), .stop_valve_closed_i(pin[7]), .valve_hydraulic_oil_loss_i(pin[8]),
    .first_stage_low_i(pin[9]), .power_range_flux_monitor_trip_i(pin[10]),
    .startup_range_flux_i(pin[11]), .startup_range_period_i(pin[12]),
    .startup_range_inop_i(pin[13]), .chan_byp_sw_i(pin[14]), .div_byp_sw_i(pin[15]),
    .accum_byp_sw_i(accum), .mode_sw_i(mode), .manual_pb_a_i(pb_a), .manual_pb_b_i(pb_b),
    .scram_o, .div_trip_o, .chan_byp_flag_o, .div_byp_flag_o, .accum_byp_flag_o,
    .siv_chan_byp_flag_o);

  plant_model u_plant_model (.mclk_i, .pin_o(pin), .mode_o(mode), .accum_o(accum),
                             .pb_a_o(pb_a), .pb_b_o(pb_b));

  // 20 MHz clock
  initial begin
    mclk_i = 1'b0;
    forever #25 mclk_i = ~mclk_i;
  end

  // ==========================================
  // checking and bus tasks
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // compare each read answer with the oldest note
  always @(posedge mclk_i) begin
    rd_d <= rd_i;
    if (rd_d === 1'b1) check(rdata_o, exp_q.pop_front());
  end

  // one write, or one read whose expected word is d
  task automatic bus(input logic w, input logic [7:0] ad, input logic [31:0] d);
    @(posedge mclk_i);
    wr_i    <= w;
    rd_i    <= !w;
    addr_i  <= ad;
    wdata_i <= d;
    if (!w) exp_q.push_back(d);
    @(posedge mclk_i);
    wr_i <= 1'b0;
    rd_i <= 1'b0;
  endtask

  task automatic settle;
    repeat (10) @(posedge mclk_i);
  endtask

  task automatic see(input logic e);
    check({31'h0, scram_o}, {31'h0, e});
  endtask

  task automatic clear(input logic [31:0] e);
    settle;
    bus(1'b1, REG_CTRL, 32'h1);
    bus(1'b0, REG_STATUS, e);
  endtask

  // scram expected for one tripped group in a mode
  function automatic logic exp_scram(int g, logic [1:0] m, logic f);
    case (g)
      S_SIV_CLOSE:            return m == MODE_RUN;
      S_STOP_VLV, S_FAST_CLS: return m == MODE_RUN && !f;
      11, 12, 13:             return m != MODE_RUN;
      default:                return 1'b1;
    endcase
  endfunction

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // ==========================================
  // main sequence
  initial begin
    void'($urandom(32'hE7C2D554));
    {rstn_i, wr_i, rd_i, addr_i, wdata_i} = '0;
    n_mismatch = 0;
    samples_checked = 0;
    repeat (3) @(posedge mclk_i);
    see(1'b0);
    rstn_i <= 1'b1;
    // reset values and refused writes
    bus(1'b0, REG_SIV, {28'h0, SIV_RST});
    bus(1'b1, REG_STATUS, 32'hFFFFFFFF);
    bus(1'b1, 8'hF0, 32'hFFFFFFFF);
    bus(1'b0, 8'hF0, 32'h0);
    bus(1'b0, REG_STATUS, 32'h0);
    bus(1'b0, REG_TRIPS, 32'h0);
    // channel bypass, second request ignored
    u_plant_model.put(14, 4'h2);
    settle;
    u_plant_model.put(14, 4'h3);
    settle;
    bus(1'b0, REG_STATUS, 32'h20);
    check({28'h0, chan_byp_flag_o}, 32'h2);
    u_plant_model.put(0, 4'h3);
    settle;
    see(1'b0);
    u_plant_model.put(0, 4'h5);
    settle;
    see(1'b1);
    bus(1'b0, REG_TRIPS, 32'h10F);
    u_plant_model.put(0, 4'h0);
    clear(32'h20);
    u_plant_model.put(10, 4'h3);
    settle;
    bus(1'b0, REG_TRIPS, 32'h2F0);
    u_plant_model.put(10, 4'h0);
    u_plant_model.put(14, 4'h0);
    clear(32'h0);
    // division bypass with per-division modes
    u_plant_model.sw({MODE_RUN, MODE_RUN, MODE_REFUEL, MODE_SHUTDOWN}, 1'b1, 1'b0, 1'b0);
    u_plant_model.put(15, 4'h8);
    settle;
    u_plant_model.put(15, 4'hC);
    settle;
    bus(1'b0, REG_STATUS, 32'h3800);
    check({28'h0, div_byp_flag_o}, 32'h8);
    check({28'h0, accum_byp_flag_o}, 32'h3);
    u_plant_model.put(5, 4'h3);
    settle;
    see(1'b0);
    check({28'h0, div_trip_o}, 32'hC);
    u_plant_model.put(15, 4'h0);
    settle;
    see(1'b1);
    u_plant_model.sw({MODE_RUN, MODE_RUN, MODE_STARTUP, MODE_STARTUP}, 1'b1, 1'b0, 1'b0);
    settle;
    bus(1'b0, REG_STATUS, 32'h1);
    check({28'h0, accum_byp_flag_o}, 32'h0);
    u_plant_model.put(5, 4'h0);
    u_plant_model.sw(8'hFF, 1'b0, 1'b1, 1'b0);
    clear(32'h0);
    // manual buttons
    see(1'b0);
    u_plant_model.sw(8'hFF, 1'b0, 1'b1, 1'b1);
    settle;
    bus(1'b0, REG_STATUS, 32'h10001);
    u_plant_model.sw(8'hFF, 1'b0, 1'b0, 1'b0);
    settle;
    bus(1'b0, REG_STATUS, 32'h1);
    clear(32'h0);
    // single channel isolation valve bypass
    bus(1'b1, REG_SIV, 32'h3);
    bus(1'b0, REG_SIV, 32'h0);
    bus(1'b1, REG_SIV, 32'h1);
    u_plant_model.put(6, 4'h3);
    settle;
    see(1'b0);
    check({28'h0, siv_chan_byp_flag_o}, 32'h1);
    u_plant_model.put(14, 4'h4);
    settle;
    bus(1'b0, REG_SIV, 32'h0);
    check({28'h0, siv_chan_byp_flag_o}, 32'h0);
    check({28'h0, chan_byp_flag_o}, 32'h4);
    see(1'b1);
    u_plant_model.put(6, 4'h0);
    u_plant_model.put(14, 4'h0);
    clear(32'h0);
    // every group in every mode, permissive low and high
    for (int m = 0; m < 4; m++) begin
      for (int f = 0; f < 2; f++) begin
        for (int g = 0; g < 14; g++) begin
          if (g == 9) continue;
          a = $urandom_range(3, 0);
          c = (4'h1 << a) | (4'h1 << ((a + $urandom_range(3, 1)) % 4));
          s = exp_scram(g, m[1:0], f[0]);
          t = g < 9 ? {22'h0, 1'b0, s, 4'h0, {4{s}}} : {22'h0, s, 1'b0, {4{s}}, 4'h0};
          u_plant_model.sw({4{m[1:0]}}, 1'b0, 1'b0, 1'b0);
          u_plant_model.put(9, {4{f[0]}});
          u_plant_model.put(g, c);
          settle;
          see(s);
          bus(1'b0, REG_TRIPS, t);
          u_plant_model.put(g, 4'h0);
          settle;
          bus(1'b0, REG_STATUS, {31'h0, s});
          clear(32'h0);
        end
      end
    end
    for (int i = 0; i < 20 && exp_q.size() > 0; i++) @(posedge mclk_i);
    if (exp_q.size() > 0) n_mismatch++;
    wrap_up;
  end
endmodule
